// [tsr_defines.svh]
// Constants for the two-step egress timestamp request and return link
// Function
// - Client raises request with valid and start
// - Client gives fingerprint with each request
// - Fingerprint reused only after its stamp returns
// - Stamp valid marks stamp and matching fingerprint
// - Stamps return in request acceptance order
// - Stamp is 96 bits per lane
// - All signals on one transmit clock
// - Request and start are one bit per lane; valid is one bit for both lanes
// - Lane 0 request needs valid and low start
// - Lane 1 request needs valid and high start
// - Fingerprint supplied for one-step packets too
// - Client cycles through a wide fingerprint range
// - Each stamp half meaningful only with its valid
// - One return bus for both packet kinds; the device returns stamps for two-step requests only
// - Time of day: seconds, nanoseconds, fraction
// - Ready drops while time of day invalid
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_LANES 2
`define TSR_FP_W 8
`define TSR_TS_W 96
`define TSR_SEC_HI 95
`define TSR_SEC_LO 48
`define TSR_NS_HI 47
`define TSR_NS_LO 16
`define TSR_FRAC_HI 15
`define TSR_FRAC_LO 0
`define TSR_DEPTH 16
`define TSR_PTR_W 4
`define TSR_CNT_W 5
`define TSR_CLI_LIMIT 5'h08
`define TSR_ONE_CNT 5'h01
`define TSR_TWO_CNT 5'h02
`define TSR_ZERO_CNT 5'h00
`endif

// [tsr_pkg.sv]
// Types shared by both ends of the timestamp link
`include "tsr_defines.svh"
package tsr_pkg;
    typedef logic [`TSR_FP_W-1:0] tsr_fp_t;
    typedef logic [`TSR_TS_W-1:0] tsr_stamp_t;
    typedef logic [`TSR_CNT_W-1:0] tsr_cnt_t;
    typedef logic [`TSR_PTR_W-1:0] tsr_ptr_t;
    typedef struct packed {
        tsr_stamp_t stamp;
        tsr_fp_t fp;
    } tsr_entry_s;
endpackage : tsr_pkg

// [tsr_link_if.sv]
// Interface joining the client transmit logic and the stamp device
`timescale 1ns/10ps
`include "tsr_defines.svh"
interface tsr_link_if;
    logic tx_valid;
    logic [`TSR_LANES-1:0] tx_sop;
    logic [`TSR_LANES-1:0] two_step_stamp_request;
    logic [`TSR_LANES*`TSR_FP_W-1:0] request_fingerprint;
    logic [`TSR_LANES-1:0] egress_stamp_valid;
    logic [`TSR_LANES*`TSR_TS_W-1:0] egress_stamp;
    logic [`TSR_LANES*`TSR_FP_W-1:0] egress_stamp_fingerprint;
    logic ptp_ready;
    modport dev (
        input tx_valid, tx_sop, two_step_stamp_request, request_fingerprint,
        output egress_stamp_valid, egress_stamp, egress_stamp_fingerprint, ptp_ready
    );
    modport cli (
        output tx_valid, tx_sop, two_step_stamp_request, request_fingerprint,
        input egress_stamp_valid, egress_stamp, egress_stamp_fingerprint, ptp_ready
    );
endinterface : tsr_link_if

// [tsr_device.sv]
// Device end: captures time of day per request, returns stamps in order
`timescale 1ns/10ps
`include "tsr_defines.svh"
module tsr_device (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Time of day
    input wire logic [`TSR_TS_W-1:0] tod_i,
    input wire logic tod_valid_i,
    // Link
    tsr_link_if.dev link
);
    // ==========================================================
    // Request acceptance
    // ==========================================================
    // Lane 1 is written after lane 0 so a cycle with two starts keeps order
    logic wr0;
    logic wr1;
    logic rd0;
    logic rd1;
    tsr_pkg::tsr_cnt_t cnt_r;
    tsr_pkg::tsr_cnt_t cnt_nxt;
    tsr_pkg::tsr_ptr_t wp_r;
    tsr_pkg::tsr_ptr_t rp_r;
    tsr_pkg::tsr_entry_s mem [`TSR_DEPTH];
    tsr_pkg::tsr_stamp_t stamp_now;

    // Same time of day for both lanes; field layout is seconds, ns, fraction
    assign stamp_now = {tod_i[`TSR_SEC_HI:`TSR_SEC_LO], tod_i[`TSR_NS_HI:`TSR_NS_LO],
                        tod_i[`TSR_FRAC_HI:`TSR_FRAC_LO]};
    assign wr0 = link.tx_valid & link.tx_sop[0] & link.two_step_stamp_request[0];
    assign wr1 = link.tx_valid & link.tx_sop[1] & link.two_step_stamp_request[1];
    assign rd0 = (cnt_r != `TSR_ZERO_CNT);
    assign rd1 = (cnt_r >= `TSR_TWO_CNT);

    always_comb begin
        cnt_nxt = cnt_r + tsr_pkg::tsr_cnt_t'(wr0) + tsr_pkg::tsr_cnt_t'(wr1)
                  - tsr_pkg::tsr_cnt_t'(rd0) - tsr_pkg::tsr_cnt_t'(rd1);
    end

    // ==========================================================
    // Stamp queue
    // ==========================================================
    // Depth covers the client's in-flight cap; an overrun would lose stamps
    always_ff @(posedge clock_i) begin
        if (ce_i) begin
            if (wr0) begin
                mem[wp_r] <= '{stamp: stamp_now, fp: link.request_fingerprint[`TSR_FP_W-1:0]};
            end
            if (wr1) begin
                mem[wp_r + tsr_pkg::tsr_ptr_t'(wr0)] <= '{stamp: stamp_now,
                    fp: link.request_fingerprint[2*`TSR_FP_W-1:`TSR_FP_W]};
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= `TSR_ZERO_CNT;
        end else if (ce_i) begin
            wp_r <= wp_r + tsr_pkg::tsr_ptr_t'(wr0) + tsr_pkg::tsr_ptr_t'(wr1);
            rp_r <= rp_r + tsr_pkg::tsr_ptr_t'(rd0) + tsr_pkg::tsr_ptr_t'(rd1);
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================================
    // Return bus
    // ==========================================================
    // Oldest entry to lane 0, next oldest to lane 1; only two-step requests get a stamp on this bus
    tsr_pkg::tsr_entry_s out0;
    tsr_pkg::tsr_entry_s out1;
    assign out0 = mem[rp_r];
    assign out1 = mem[rp_r + tsr_pkg::tsr_ptr_t'(1)];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link.egress_stamp_valid <= '0;
            link.egress_stamp <= '0;
            link.egress_stamp_fingerprint <= '0;
        end else if (ce_i) begin
            link.egress_stamp_valid <= {rd1, rd0};
            if (rd0) begin
                link.egress_stamp[`TSR_TS_W-1:0] <= out0.stamp;
                link.egress_stamp_fingerprint[`TSR_FP_W-1:0] <= out0.fp;
            end
            if (rd1) begin
                link.egress_stamp[2*`TSR_TS_W-1:`TSR_TS_W] <= out1.stamp;
                link.egress_stamp_fingerprint[2*`TSR_FP_W-1:`TSR_FP_W] <= out1.fp;
            end
        end
    end

    // ==========================================================
    // Ready
    // ==========================================================
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link.ptp_ready <= 1'b0;
        end else if (ce_i) begin
            link.ptp_ready <= tod_valid_i;
        end
    end
endmodule : tsr_device

// [tsr_client.sv]
// Client end: tags packet starts with requests and rolling fingerprints
`timescale 1ns/10ps
`include "tsr_defines.svh"
module tsr_client (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // User packet side
    input wire logic pkt_valid_i,
    input wire logic [`TSR_LANES-1:0] pkt_sop_i,
    input wire logic [`TSR_LANES-1:0] pkt_stamp_i,
    output logic pkt_accept_o,
    // User stamp side
    output logic [`TSR_LANES-1:0] stamp_valid_o,
    output logic [`TSR_LANES*`TSR_TS_W-1:0] stamp_o,
    output logic [`TSR_LANES*`TSR_FP_W-1:0] stamp_fp_o,
    output logic ready_o,
    // Link
    tsr_link_if.cli link
);
    // ==========================================================
    // Issue
    // ==========================================================
    // Capping in-flight stamps keeps every live fingerprint distinct
    tsr_pkg::tsr_cnt_t out_r;
    tsr_pkg::tsr_fp_t seq_r;
    logic [`TSR_LANES-1:0] req;
    logic [`TSR_LANES-1:0] ret;
    logic take;

    assign pkt_accept_o = (out_r + `TSR_TWO_CNT <= `TSR_CLI_LIMIT);
    assign take = ce_i & pkt_valid_i & pkt_accept_o;
    assign req = pkt_sop_i & pkt_stamp_i & {`TSR_LANES{take}};
    assign ret = link.egress_stamp_valid;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link.tx_valid <= 1'b0;
            link.tx_sop <= '0;
            link.two_step_stamp_request <= '0;
            link.request_fingerprint <= '0;
        end else if (ce_i) begin
            link.tx_valid <= take;
            link.tx_sop <= pkt_sop_i & {`TSR_LANES{take}};
            link.two_step_stamp_request <= req;
            // Every start gets a fingerprint, stamped or not
            link.request_fingerprint <= {seq_r + tsr_pkg::tsr_fp_t'(pkt_sop_i[0]), seq_r};
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_r <= '0;
        end else if (take) begin
            // Rolling count walks the whole fingerprint range
            seq_r <= seq_r + tsr_pkg::tsr_fp_t'(pkt_sop_i[0]) + tsr_pkg::tsr_fp_t'(pkt_sop_i[1]);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_r <= `TSR_ZERO_CNT;
        end else if (ce_i) begin
            out_r <= out_r + tsr_pkg::tsr_cnt_t'(req[0]) + tsr_pkg::tsr_cnt_t'(req[1])
                     - tsr_pkg::tsr_cnt_t'(ret[0]) - tsr_pkg::tsr_cnt_t'(ret[1]);
        end
    end

    // ==========================================================
    // Returned stamps
    // ==========================================================
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stamp_valid_o <= '0;
            stamp_o <= '0;
            stamp_fp_o <= '0;
            ready_o <= 1'b0;
        end else if (ce_i) begin
            stamp_valid_o <= ret;
            stamp_o <= link.egress_stamp;
            stamp_fp_o <= link.egress_stamp_fingerprint;
            ready_o <= link.ptp_ready;
        end
    end
endmodule : tsr_client

// [tsr_end_marker_unused.sv]
// Empty compilation unit reserved for build ordering
`timescale 1ns/10ps

// [tsr_link_sva.sv]
// Checker for the stamp link between client and device ends
`timescale 1ns/10ps
`include "tsr_defines.svh"
module tsr_link_sva (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Link
    input wire logic tx_valid,
    input wire logic [`TSR_LANES-1:0] tx_sop,
    input wire logic [`TSR_LANES-1:0] two_step_stamp_request,
    input wire logic [`TSR_LANES*`TSR_FP_W-1:0] request_fingerprint,
    input wire logic [`TSR_LANES-1:0] egress_stamp_valid,
    input wire logic [`TSR_LANES*`TSR_TS_W-1:0] egress_stamp,
    input wire logic [`TSR_LANES*`TSR_FP_W-1:0] egress_stamp_fingerprint,
    input wire logic ptp_ready
);
    // ========
    // Outstanding requests, so an empty queue can be told apart
    logic [1:0] tk;
    logic [5:0] pend_r;
    assign tk = {2{tx_valid}} & tx_sop & two_step_stamp_request;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_r <= 6'h00;
        end else begin
            pend_r <= pend_r + 6'(tk[0]) + 6'(tk[1])
                - 6'(egress_stamp_valid[0]) - 6'(egress_stamp_valid[1]);
        end
    end
    // ========
    // Properties
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    req_low_a: assert property (two_step_stamp_request[0] |-> tx_valid && tx_sop[0])
        else $error("lane 0 request without start");
    req_high_a: assert property (two_step_stamp_request[1] |-> tx_valid && tx_sop[1])
        else $error("lane 1 request without start");
    // Device writes its queue at the take edge and reads it one edge later, so the
    // registered stamp is sampled two edges after the request was sampled
    empty_answer_a: assert property (tk != 2'h0 && pend_r == 6'h00 |-> ##2 egress_stamp_valid[0])
        else $error("no stamp two cycles after request");
    fp_match_a: assert property (tk == 2'h1 && pend_r == 6'h00 |-> ##2
        egress_stamp_fingerprint[7:0] == $past(request_fingerprint[7:0], 2))
        else $error("returned fingerprint differs");
    both_lane_a: assert property (tk == 2'h3 && pend_r == 6'h00 |-> ##2 egress_stamp_valid == 2'h3
        && egress_stamp_fingerprint == $past(request_fingerprint, 2)) else $error("lane pair wrong");
    no_spare_a: assert property (6'($countones(egress_stamp_valid)) <= pend_r)
        else $error("stamp without request");
    lane_order_a: assert property (egress_stamp_valid[1] |-> egress_stamp_valid[0])
        else $error("lane 1 stamp before lane 0");
    drain_bound_a: assert property (pend_r != 6'h00 |-> ##[0:8] egress_stamp_valid != 2'h0)
        else $error("pending stamp not returned");
    stamp_hold_a: assert property (!egress_stamp_valid[0] |-> $stable(egress_stamp[95:0]))
        else $error("stamp moved without valid");
endmodule : tsr_link_sva

// [tx_two_step_ptp_timestamp_test.sv]
// Testbench joining client and device ends over the stamp link
`timescale 1ns/10ps
`include "tsr_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tx_two_step_ptp_timestamp_test;
    logic clock_i = 1'b0, arst_n_i = 1'b0, pkt_valid_i = 1'b0, tod_valid_i = 1'b1;
    logic accept, ready, h0 = 1'b0, h1 = 1'b0;
    logic [1:0] sop = 2'h0, st = 2'h0, sv;
    logic [95:0] tod = 96'h0;
    logic [191:0] so;
    logic [15:0] sf;
    logic [7:0] seq = 8'h00;
    logic [7:0] pl[$];
    logic [103:0] q[$];
    int n_mismatch = 0, total_checks = 0;
    tsr_link_if lk ();
    tsr_device i_tsr_device (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .tod_i(tod),
        .tod_valid_i(tod_valid_i), .link(lk.dev));
    tsr_client i_tsr_client (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
        .pkt_valid_i(pkt_valid_i), .pkt_sop_i(sop), .pkt_stamp_i(st), .pkt_accept_o(accept),
        .stamp_valid_o(sv), .stamp_o(so), .stamp_fp_o(sf), .ready_o(ready), .link(lk.cli));
    tsr_link_sva i_tsr_link_sva (.clock_i(clock_i), .arst_n_i(arst_n_i), .tx_valid(lk.tx_valid),
        .tx_sop(lk.tx_sop), .two_step_stamp_request(lk.two_step_stamp_request),
        .request_fingerprint(lk.request_fingerprint), .egress_stamp_valid(lk.egress_stamp_valid),
        .egress_stamp(lk.egress_stamp), .egress_stamp_fingerprint(lk.egress_stamp_fingerprint),
        .ptp_ready(lk.ptp_ready));
    // ========
    // Expected fingerprint of a lane: lane 1 follows lane 0 when both start together
    function automatic logic [7:0] lane_fp(input logic [7:0] base, input logic [1:0] s,
                                           input int lane);
        lane_fp = base + (((lane == 1) && s[0]) ? 8'h01 : 8'h00);
    endfunction : lane_fp
    // ========
    // Reference: stamp is the time of day at the edge the device takes the request
    always @(posedge clock_i) begin
        if (arst_n_i) begin
            foreach (pl[i]) q.push_back({pl[i], tod});
            pl.delete();
            if (pkt_valid_i && accept === 1'b1) begin
                if (sop[0] && st[0]) pl.push_back(lane_fp(seq, sop, 0));
                if (sop[1] && st[1]) pl.push_back(lane_fp(seq, sop, 1));
                seq = seq + 8'(sop[0]) + 8'(sop[1]);
            end
            for (int l = 0; l < 2; l++) begin
                if (sv[l] === 1'b1 && q.size() == 0) `CHK("spare", 1'b0, 1'b1)
                else if (sv[l] === 1'b1) begin
                    `CHK("fp", q[0][103:96], sf[l*8+:8])
                    `CHK("stamp", q[0][95:0], so[l*96+:96])
                    void'(q.pop_front());
                end
            end
            `CHK("ready", h1, ready)
            h1 = h0;
            h0 = tod_valid_i;
        end
    end
    // ========
    // Stimulus
    task automatic beat(input logic v, input logic [1:0] s, input logic [1:0] t, input logic tv);
        @(posedge clock_i);
        pkt_valid_i <= v;
        sop <= s;
        st <= t;
        tod_valid_i <= tv;
        tod <= {$urandom(), $urandom(), $urandom()};
    endtask : beat
    task automatic run(input string nm, input int mode, input int n);
        for (int i = 0; i < n; i++) begin
            if (mode == 0) beat(1'b1, 2'h1, 2'h1, 1'b1);
            else if (mode == 1) beat(1'b1, 2'h3, 2'h3, 1'b1);
            else beat(1'($urandom()), 2'($urandom()), 2'($urandom()), $urandom() % 4 != 0);
        end
        repeat (40) beat(1'b0, 2'h0, 2'h0, 1'b1);
        $display("test %s done", nm);
    endtask : run
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    initial begin
        void'($urandom(5680));
        repeat (8) @(posedge clock_i);
        arst_n_i <= 1'b1;
        run("single", 0, 1);
        run("cap", 1, 30); // Back to back on both lanes for 30 beats; accept stays high at three pairs in flight
        run("random", 2, 2000);
        `CHK("left", 0, q.size())
        close_out();
    end
    initial begin
        repeat (10000) @(posedge clock_i);
        n_mismatch++;
        close_out();
    end
endmodule : tx_two_step_ptp_timestamp_test
